// File: src/gcr_consts.svh
// Constants for the port, routing and conversion configuration register bank.
`ifndef GCR_CONSTS_SVH
`define GCR_CONSTS_SVH

`define GCR_ADDR_PORT 8'h14
`define GCR_ADDR_ROUTE 8'h15
`define GCR_ADDR_SPARE 8'h16
`define GCR_ADDR_CONV 8'h17
`define GCR_RST_PORT 8'h0f
`define GCR_RST_ROUTE 8'h00
`define GCR_RST_SPARE 8'h00
`define GCR_RST_CONV 8'h00
`define GCR_DATA_HI 7
`define GCR_DATA_LO 4
`define GCR_DIR_HI 3
`define GCR_DIR_LO 0
`define GCR_ROUTE_BIT 5
`define GCR_SINGLE_BIT 3
`define GCR_COMP_BIT 1
`define GCR_RESP_M01 2'h1
`define GCR_RESP_M11 2'h3
`define GCR_PIN_COUNT 4
`define GCR_RST_DIR 4'hf
`define GCR_RST_DATA 4'h0
`define GCR_RST_BIT 1'b0
`define GCR_RD_NONE 8'h00
`define GCR_AVAIL_RESP 4'h1
`define GCR_AVAIL_ALL 4'hf
`define GCR_PIN_IDLE 4'h0

`endif

// File: src/gcr_pkg.sv
// Types shared by the register bank modules.
package gcr_pkg;
    typedef logic [7:0] gcr_byte_t;
    typedef logic [3:0] gcr_nib_t;
endpackage : gcr_pkg

// File: src/gcr_pin_if.sv
// Bundle between the register bank and the pin stage.
`timescale 1ns/1ps
`default_nettype none
interface gcr_pin_if;
    logic [3:0] dir_in;
    logic [3:0] out_val;
    logic [3:0] avail;
    logic [3:0] level;
    modport bank (output dir_in, output out_val, output avail, input level);
    modport pins (input dir_in, input out_val, input avail, output level);
endinterface : gcr_pin_if
`default_nettype wire

// File: src/gcr_pin_stage.sv
// Port pin stage: input synchronisers and registered drivers.
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"
module gcr_pin_stage
    import gcr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    gcr_pin_if.pins pif,
    input wire gcr_pkg::gcr_nib_t pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe
);
    import gcr_pkg::*;

    gcr_nib_t sync1_reg;
    gcr_nib_t sync2_reg;
    gcr_nib_t oe_next;

    // Withdrawn pins are released so the respiration logic owns them.
    assign oe_next = ~pif.dir_in & pif.avail;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_reg <= `GCR_PIN_IDLE;
            sync2_reg <= `GCR_PIN_IDLE;
            pin_out <= `GCR_PIN_IDLE;
            pin_oe <= `GCR_PIN_IDLE;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            pin_out <= pif.out_val;
            pin_oe <= oe_next;
        end
    end

    assign pif.level = sync2_reg;
endmodule : gcr_pin_stage
`default_nettype wire

// File: src/gcr_regs.sv
// Port, routing and conversion configuration register bank.
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"
module gcr_regs
    import gcr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire gcr_pkg::gcr_byte_t reg_addr,
    input wire gcr_pkg::gcr_byte_t reg_wdata,
    output var gcr_pkg::gcr_byte_t reg_rdata,
    input wire logic [1:0] respiration_control_field,
    input wire gcr_pkg::gcr_nib_t pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic shared_reference_route,
    output logic single_shot_mode,
    output logic detach_comparator_power
);
    import gcr_pkg::*;

    // Bundle to the pin stage, which owns the pad synchronisers and drivers.
    gcr_pin_if pif();

    // Stored register images.
    gcr_nib_t dir_reg;
    gcr_nib_t latch_reg;
    gcr_byte_t route_reg;
    gcr_byte_t spare_reg;
    gcr_byte_t conv_reg;

    // Next values of the stored images.
    gcr_nib_t dir_next;
    gcr_nib_t latch_next;
    gcr_byte_t route_next;
    gcr_byte_t spare_next;
    gcr_byte_t conv_next;
    gcr_byte_t rdata_next;

    // Address decode and write strobes.
    logic hit_port;
    logic hit_route;
    logic hit_spare;
    logic hit_conv;
    logic hit_any;
    logic wr_port;
    logic wr_route;
    logic wr_spare;
    logic wr_conv;

    // Port field views.
    gcr_nib_t pin_direction_bits;
    gcr_nib_t pin_data_bits;
    gcr_nib_t wr_dir_field;
    gcr_nib_t wr_data_field;
    gcr_nib_t latch_load;
    gcr_byte_t port_view;

    // Read selection.
    gcr_byte_t read_port;
    gcr_byte_t read_route;
    gcr_byte_t read_spare;
    gcr_byte_t read_conv;
    gcr_byte_t read_mux;

    // Respiration ownership of the upper pins.
    logic resp_mode_lo;
    logic resp_mode_hi;
    logic resp_owns;
    gcr_nib_t pin_avail;

    // Control bits taken from the stored images.
    logic route_bit;
    logic single_bit;
    logic comp_bit;

    assign hit_port = reg_addr == `GCR_ADDR_PORT;
    assign hit_route = reg_addr == `GCR_ADDR_ROUTE;
    assign hit_spare = reg_addr == `GCR_ADDR_SPARE;
    assign hit_conv = reg_addr == `GCR_ADDR_CONV;
    assign hit_any = hit_port | hit_route | hit_spare | hit_conv;

    // Writes to any other address match no strobe and leave every image alone.
    assign wr_port = reg_wr & hit_port;
    assign wr_route = reg_wr & hit_route;
    assign wr_spare = reg_wr & hit_spare;
    assign wr_conv = reg_wr & hit_conv;

    assign wr_dir_field = reg_wdata[`GCR_DIR_HI:`GCR_DIR_LO];
    assign wr_data_field = reg_wdata[`GCR_DATA_HI:`GCR_DATA_LO];
    assign pin_direction_bits = dir_reg;
    assign pin_data_bits = latch_reg;

    assign resp_mode_lo = respiration_control_field == `GCR_RESP_M01;
    assign resp_mode_hi = respiration_control_field == `GCR_RESP_M11;
    assign resp_owns = resp_mode_lo | resp_mode_hi;
    assign pin_avail = resp_owns ? `GCR_AVAIL_RESP : `GCR_AVAIL_ALL;

    // A data bit only loads while its pin is an output before the write. The direction
    // written in the same access acts one edge later, so a pin turned to output first
    // drives the level it already held.
    generate
        for (genvar i = 0; i < `GCR_PIN_COUNT; i++) begin : g_latch
            assign latch_load[i] = wr_port & ~pin_direction_bits[i];
            assign latch_next[i] = latch_load[i] ? wr_data_field[i]
                                 : latch_reg[i];
        end
    endgenerate

    assign dir_next = wr_port ? wr_dir_field : dir_reg;
    assign route_next = wr_route ? reg_wdata : route_reg;
    // Reserved bits are kept as written; the host is expected to write zeros here.
    assign spare_next = wr_spare ? reg_wdata : spare_reg;
    assign conv_next = wr_conv ? reg_wdata : conv_reg;

    assign pif.dir_in = pin_direction_bits;
    assign pif.out_val = pin_data_bits;
    assign pif.avail = pin_avail;

    gcr_pin_stage u_pins (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pif(pif),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    // The data field shows the synchronised pads, never the latch, so a read lags a
    // pad change by the two synchroniser stages.
    assign port_view = {pif.level, pin_direction_bits};
    assign read_port = hit_port ? port_view : `GCR_RD_NONE;
    assign read_route = hit_route ? route_reg : `GCR_RD_NONE;
    assign read_spare = hit_spare ? spare_reg : `GCR_RD_NONE;
    assign read_conv = hit_conv ? conv_reg : `GCR_RD_NONE;
    assign read_mux = hit_any ? (read_port | read_route | read_spare | read_conv)
                              : `GCR_RD_NONE;
    // A read in the same cycle as a write returns the image from before the write.
    assign rdata_next = reg_rd ? read_mux : reg_rdata;

    assign route_bit = route_reg[`GCR_ROUTE_BIT];
    assign single_bit = conv_reg[`GCR_SINGLE_BIT];
    assign comp_bit = conv_reg[`GCR_COMP_BIT];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dir_reg <= `GCR_RST_DIR;
        end else begin
            dir_reg <= dir_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            latch_reg <= `GCR_RST_DATA;
        end else begin
            latch_reg <= latch_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            route_reg <= `GCR_RST_ROUTE;
        end else begin
            route_reg <= route_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            spare_reg <= `GCR_RST_SPARE;
        end else begin
            spare_reg <= spare_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            conv_reg <= `GCR_RST_CONV;
        end else begin
            conv_reg <= conv_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= `GCR_RD_NONE;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shared_reference_route <= `GCR_RST_BIT;
        end else begin
            shared_reference_route <= route_bit;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            single_shot_mode <= `GCR_RST_BIT;
        end else begin
            single_shot_mode <= single_bit;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            detach_comparator_power <= `GCR_RST_BIT;
        end else begin
            detach_comparator_power <= comp_bit;
        end
    end
endmodule : gcr_regs
`default_nettype wire

// File: testbench/gcr_regs_asserts.sv
// Port, routing, conversion, unmapped-read and reset checks for the register bank.
`timescale 1ns/1ps
`default_nettype none
module gcr_regs_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire gcr_pkg::gcr_byte_t reg_addr,
    input wire gcr_pkg::gcr_byte_t reg_wdata,
    input wire gcr_pkg::gcr_byte_t reg_rdata,
    input wire logic [1:0] respiration_control_field,
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic shared_reference_route,
    input wire logic single_shot_mode,
    input wire logic detach_comparator_power);
    wire port_wr = reg_wr && reg_addr == 8'h14;
    wire no_rsp = respiration_control_field == 2'h0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    oe_dir_a: assert property (port_wr && no_rsp ##1 no_rsp
        |=> pin_oe == ~$past(reg_wdata[3:0], 2)) else $error("pin enable wrong");
    out_val_a: assert property (port_wr && no_rsp ##1 no_rsp |=>
        ((pin_out ^ $past(reg_wdata[7:4], 2)) & pin_oe & $past(pin_oe)) == 4'h0)
        else $error("pin level wrong");
    withdrawn_pins_a: assert property (respiration_control_field[0] [*2] |=>
        !pin_oe[3:1])
        else $error("withdrawn pin driven");
    route_switch_a: assert property (reg_wr && reg_addr == 8'h15 |=> ##1
        shared_reference_route == $past(reg_wdata[5], 2)) else $error("route wrong");
    single_shot_a: assert property (reg_wr && reg_addr == 8'h17 |=> ##1
        single_shot_mode == $past(reg_wdata[3], 2)) else $error("mode wrong");
    comp_power_a: assert property (reg_wr && reg_addr == 8'h17 |=> ##1
        detach_comparator_power == $past(reg_wdata[1], 2)) else $error("comparator wrong");
    unmapped_read_a: assert property (reg_rd && !(reg_addr inside {[8'h14:8'h17]})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    reset_values_a: assert property (disable iff (1'b0) !rst_n |=> !{pin_oe,
        shared_reference_route, single_shot_mode, detach_comparator_power}) else $error("no reset");
    cover property (port_wr ##1 no_rsp);
    cover property (respiration_control_field == 2'h3 ##1 pin_oe == 4'h1);
    cover property ($rose(shared_reference_route));
endmodule : gcr_regs_asserts
bind gcr_regs gcr_regs_asserts chk (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .respiration_control_field, .pin_out, .pin_oe, .shared_reference_route,
    .single_shot_mode, .detach_comparator_power);
`default_nettype wire

// File: testbench/gcr_regs_tb.sv
// Self-checking bench for the register bank.
`timescale 1ns/1ps
`default_nettype none
module gcr_regs_tb;
    import gcr_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, route, single, comp;
    gcr_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [3:0] pad = 4'h5, pin_out, pin_oe;
    logic [1:0] resp = 2'h0;
    int error_cnt = 0, n_checks = 0;
    logic [24:0] rows [16] = '{25'h0150000, 25'h0160000, 25'h0170000, 25'h014005f, 25'h114af00,
        25'h014005f, 25'h1143000, 25'h0140000, 25'h114c900, 25'h0140059, 25'h1152000,
        25'h0150020, 25'h1170a00, 25'h0170a0a, 25'h118ff00, 25'h0180000};
    // Pads are resolved here so an input pin shows the outside level, not the driver.
    wire gcr_nib_t pin_lvl = (pin_oe & pin_out) | (~pin_oe & pad);
    gcr_regs dut (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .respiration_control_field(resp), .pin_in(pin_lvl), .pin_out, .pin_oe,
        .shared_reference_route(route), .single_shot_mode(single), .detach_comparator_power(comp));
    initial forever #50 core_clk = ~core_clk;
    // The trailing wait covers the two-flop pin synchroniser before any compare.
    task automatic bus(input logic w, input gcr_byte_t a, input gcr_byte_t d);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        {reg_wr, reg_rd} <= 2'b00;
        repeat (5) @(negedge core_clk);
    endtask : bus
    task automatic chk(input gcr_byte_t got, input gcr_byte_t exp);
        n_checks++;
        if (got !== exp) $display("Error at %0t: got %h want %h", $time, got, exp);
        error_cnt += int'(got !== exp);
    endtask : chk
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            bus(rows[i][24], rows[i][23:16], rows[i][15:8]);
            if (!rows[i][24]) chk(reg_rdata, rows[i][7:0]);
        end
        chk({5'h00, route, single, comp}, 8'h07);
        $display("register table done");
        bus(1'b1, 8'h14, 8'hf0);
        chk({pin_out, pin_oe}, 8'hef);
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            resp <= m[1:0];
            repeat (3) @(negedge core_clk);
            chk({4'h0, pin_oe}, m[0] ? 8'h01 : 8'h0f);
        end
        $display("mode test done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk({pin_oe, 1'b0, route, single, comp}, 8'h00);
        bus(1'b0, 8'h17, 8'h00);
        chk(reg_rdata, 8'h00);
        $display("reset test done");
        stop_test();
    end
endmodule : gcr_regs_tb
`default_nettype wire
